// ===== include/dac_ctrl_pkg.sv
// Shared constants, frame and state types for the converter control block
// Behaviour
// R1: A one in a software control bit acts exactly like a low pin pulse.
// R2: Host reaches software control with write bit 0 and address 1,0,0.
// R3: Software load bit transfers pending input value into converter register.
// R4: Software clear bit loads converter register from the clear code.
// R5: Clear result depends on selected coding, offset binary or twos complement.
// R6: Software reset bit returns all registers and output state to power-on.
// R7: Clear requests are ignored while the load pin is held low.
// R8: Load requests are ignored while the clear pin is held low.
// R9: Power-on reset sets every register to its default value.
// R10: After power-on output is tristate and clamped until control is written.
// R11: Host clears tristate and clamp bits before programming output values.
// R12: Leaving clamp shows register default, the negative reference level.
// R13: Clamp bit wins; else tristate bit gives tristate; else normal mode.
// R14: Feedback select one connects the parallel resistor pair.
// R15: Host clears feedback select for the gain of two arrangement.
// R16: Tristate bit defaults to one after reset.
// R17: Coding bit defaults to zero, twos complement; one is offset binary.
// R18: Software strobes are one-cycle pulses at frame end, merged with pins.
package dac_ctrl_pkg;

  localparam int FRAME_BITS = 24;
  localparam int DATA_W     = 16;
  localparam int DATA_LSB   = 4;

  // Register addresses inside a frame
  localparam logic [2:0] ADDR_DAC       = 3'h1;
  localparam logic [2:0] ADDR_CTRL      = 3'h2;
  localparam logic [2:0] ADDR_CLEARCODE = 3'h3;
  localparam logic [2:0] ADDR_SWCTRL    = 3'h4;

  // Software control word bits
  localparam int SW_LOAD_BIT  = 0;
  localparam int SW_CLEAR_BIT = 1;
  localparam int SW_RESET_BIT = 2;

  // Control register bits
  localparam int CTRL_FB_BIT    = 1;
  localparam int CTRL_CLAMP_BIT = 2;
  localparam int CTRL_FLOAT_BIT = 3;
  localparam int CTRL_FMT_BIT   = 4;

  // Reset values
  localparam logic        FB_RESET       = 1'b1;
  localparam logic        CLAMP_RESET    = 1'b1;
  localparam logic        FLOAT_RESET    = 1'b1;
  localparam logic        FMT_RESET      = 1'b0;
  localparam logic [15:0] DAC_RESET      = 16'h8000;
  localparam logic [15:0] INPUT_RESET    = 16'h8000;
  localparam logic [15:0] CLEARCODE_RESET = 16'h0000;

  // Synchroniser depth for pins and the link clock
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic        rw;
    logic [2:0]  addr;
    logic [19:0] data;
  } frame_s;

  typedef enum logic [1:0] {
    OUT_NORMAL,
    OUT_TRISTATE,
    OUT_CLAMP
  } output_state_e;

endpackage : dac_ctrl_pkg

// ===== verilog/dac_frame_receiver.sv
// Three-wire serial frame receiver sampled by the system clock
`timescale 1ns/100ps
module dac_frame_receiver #(
  parameter int FRAME_BITS = 24
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_sclk,
  input  wire logic                 i_sync_b,
  input  wire logic                 i_sdin,
  output logic                      o_frame_valid,
  output dac_ctrl_pkg::frame_s      o_frame
);

  localparam int CNT_W = $clog2(FRAME_BITS + 2);

  generate
    if (FRAME_BITS != $bits(dac_ctrl_pkg::frame_s)) begin : g_bad_len
      $error("FRAME_BITS must match the frame layout");
    end
  endgenerate

  logic [2:0]            pin_meta;
  logic [2:0]            pin_sync;
  logic                  sclk_prev;
  logic                  sync_prev;
  logic [FRAME_BITS-1:0] shift;
  logic [CNT_W-1:0]      bit_cnt;
  logic                  sclk_fall;
  logic                  frame_start;
  logic                  frame_end;

  // Bit order: sclk, sync_b, sdin
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      pin_meta <= {i_sclk, i_sync_b, i_sdin};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev <= 1'b1;
      sync_prev <= 1'b1;
    end else begin
      sclk_prev <= pin_sync[2];
      sync_prev <= pin_sync[1];
    end
  end

  assign sclk_fall   = sclk_prev & ~pin_sync[2] & ~pin_sync[1];
  assign frame_start = sync_prev & ~pin_sync[1];
  assign frame_end   = ~sync_prev & pin_sync[1];

  // Shift on falling link clock edges; count saturates past a full frame
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift   <= '0;
      bit_cnt <= '0;
    end else if (frame_start) begin
      bit_cnt <= '0;
    end else if (sclk_fall) begin
      shift <= {shift[FRAME_BITS-2:0], pin_sync[0]};
      if (bit_cnt <= CNT_W'(FRAME_BITS))
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Only frames of exactly the right length are delivered
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_frame_valid <= 1'b0;
      o_frame       <= '0;
    end else begin
      o_frame_valid <= frame_end && (bit_cnt == CNT_W'(FRAME_BITS)); // R18
      if (frame_end && (bit_cnt == CNT_W'(FRAME_BITS)))
        o_frame <= shift;
    end
  end

  a_valid_single : assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_frame_valid |=> !o_frame_valid) // R18
    else $error("frame valid longer than one cycle");

endmodule : dac_frame_receiver

// ===== verilog/dac_output_state_control.sv
// Converter control: registers, load/clear/reset strobes, output state
`timescale 1ns/100ps
module dac_output_state_control #(
  parameter int DATA_W = 16
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_sclk,
  input  wire logic                  i_sync_b,
  input  wire logic                  i_sdin,
  input  wire logic                  i_load_output_strobe_b,
  input  wire logic                  i_clear_to_code_b,
  output logic [DATA_W-1:0]          o_dac_code,
  output logic                       o_dac_update,
  output dac_ctrl_pkg::output_state_e o_output_state,
  output logic                       o_converter_float_ctrl,
  output logic                       o_output_ground_clamp,
  output logic                       o_feedback_resistor_select,
  output logic                       o_code_format_select
);

  generate
    if (DATA_W != dac_ctrl_pkg::DATA_W) begin : g_bad_width
      $error("DATA_W must equal the frame data width");
    end
  endgenerate

  logic [1:0]           rst_pipe;
  logic                 rst_b;
  logic                 load_meta;
  logic                 load_sync;
  logic                 load_prev;
  logic                 clear_meta;
  logic                 clear_sync;
  logic                 clear_prev;
  logic                 frame_valid;
  dac_ctrl_pkg::frame_s frame;
  logic [DATA_W-1:0]    frame_word;
  logic                 wr;
  logic                 sw_load;
  logic                 sw_clear;
  logic                 sw_reset;
  logic                 pin_load_fall;
  logic                 pin_clear_fall;
  logic                 load_req;
  logic                 clear_req;
  logic [DATA_W-1:0]    input_reg;
  logic [DATA_W-1:0]    clear_code;
  logic [DATA_W-1:0]    dac_reg;

  // Reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_b = rst_pipe[1];

  // Pin synchronisers, idle high
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      load_meta  <= 1'b1;
      load_sync  <= 1'b1;
      load_prev  <= 1'b1;
      clear_meta <= 1'b1;
      clear_sync <= 1'b1;
      clear_prev <= 1'b1;
    end else begin
      load_meta  <= i_load_output_strobe_b;
      load_sync  <= load_meta;
      load_prev  <= load_sync;
      clear_meta <= i_clear_to_code_b;
      clear_sync <= clear_meta;
      clear_prev <= clear_sync;
    end
  end

  dac_frame_receiver #(
    .FRAME_BITS (dac_ctrl_pkg::FRAME_BITS)
  ) u_rx (
    .i_clk_sys     (i_clk_sys),
    .i_rst_b       (rst_b),
    .i_sclk        (i_sclk),
    .i_sync_b      (i_sync_b),
    .i_sdin        (i_sdin),
    .o_frame_valid (frame_valid),
    .o_frame       (frame)
  );

  assign frame_word = frame.data[dac_ctrl_pkg::DATA_LSB +: DATA_W];
  assign wr         = frame_valid && !frame.rw;

  // Software strobes, one cycle at frame end
  assign sw_load  = wr && (frame.addr == dac_ctrl_pkg::ADDR_SWCTRL)
                    && frame.data[dac_ctrl_pkg::SW_LOAD_BIT];   // R1 R18
  assign sw_clear = wr && (frame.addr == dac_ctrl_pkg::ADDR_SWCTRL)
                    && frame.data[dac_ctrl_pkg::SW_CLEAR_BIT];  // R1 R18
  assign sw_reset = wr && (frame.addr == dac_ctrl_pkg::ADDR_SWCTRL)
                    && frame.data[dac_ctrl_pkg::SW_RESET_BIT];  // R1 R6

  assign pin_load_fall  = load_prev & ~load_sync;
  assign pin_clear_fall = clear_prev & ~clear_sync;

  // Each request is locked out while the other pin is held low
  assign load_req  = (pin_load_fall | sw_load) & clear_sync;   // R8 R18
  assign clear_req = (pin_clear_fall | sw_clear) & load_sync;  // R7 R18

  // Pending input and clear code registers
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      input_reg  <= dac_ctrl_pkg::INPUT_RESET;                  // R9
      clear_code <= dac_ctrl_pkg::CLEARCODE_RESET;              // R9
    end else if (sw_reset) begin
      input_reg  <= dac_ctrl_pkg::INPUT_RESET;                  // R6
      clear_code <= dac_ctrl_pkg::CLEARCODE_RESET;              // R6
    end else if (wr) begin
      if (frame.addr == dac_ctrl_pkg::ADDR_DAC)
        input_reg <= frame_word;
      if (frame.addr == dac_ctrl_pkg::ADDR_CLEARCODE)
        clear_code <= frame_word;
    end
  end

  // Control register fields
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_feedback_resistor_select <= dac_ctrl_pkg::FB_RESET;     // R9
      o_output_ground_clamp      <= dac_ctrl_pkg::CLAMP_RESET;  // R10
      o_converter_float_ctrl     <= dac_ctrl_pkg::FLOAT_RESET;  // R16
      o_code_format_select       <= dac_ctrl_pkg::FMT_RESET;    // R17
    end else if (sw_reset) begin
      o_feedback_resistor_select <= dac_ctrl_pkg::FB_RESET;     // R6
      o_output_ground_clamp      <= dac_ctrl_pkg::CLAMP_RESET;  // R6
      o_converter_float_ctrl     <= dac_ctrl_pkg::FLOAT_RESET;  // R6
      o_code_format_select       <= dac_ctrl_pkg::FMT_RESET;    // R6
    end else if (wr && frame.addr == dac_ctrl_pkg::ADDR_CTRL) begin
      o_feedback_resistor_select <=
        frame.data[dac_ctrl_pkg::CTRL_FB_BIT];                  // R14
      o_output_ground_clamp      <=
        frame.data[dac_ctrl_pkg::CTRL_CLAMP_BIT];               // R10
      o_converter_float_ctrl     <=
        frame.data[dac_ctrl_pkg::CTRL_FLOAT_BIT];
      o_code_format_select       <=
        frame.data[dac_ctrl_pkg::CTRL_FMT_BIT];                 // R17
    end
  end

  // Converter register; clear wins over a simultaneous load
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_reg      <= dac_ctrl_pkg::DAC_RESET;                  // R12
      o_dac_update <= 1'b0;
    end else if (sw_reset) begin
      dac_reg      <= dac_ctrl_pkg::DAC_RESET;                  // R6
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= load_req | clear_req;
      if (clear_req)
        dac_reg <= clear_code;                                  // R4
      else if (load_req)
        dac_reg <= input_reg;                                   // R3
    end
  end

  // Offset-binary equivalent drives the converter core
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b)
      o_dac_code <= {~dac_ctrl_pkg::DAC_RESET[DATA_W-1],
                     dac_ctrl_pkg::DAC_RESET[DATA_W-2:0]};
    else if (o_code_format_select)
      o_dac_code <= dac_reg;                                    // R5
    else
      o_dac_code <= {~dac_reg[DATA_W-1], dac_reg[DATA_W-2:0]};  // R5
  end

  // Clamp overrides tristate
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b)
      o_output_state <= dac_ctrl_pkg::OUT_CLAMP;                // R10
    else if (o_output_ground_clamp)
      o_output_state <= dac_ctrl_pkg::OUT_CLAMP;                // R13
    else if (o_converter_float_ctrl)
      o_output_state <= dac_ctrl_pkg::OUT_TRISTATE;             // R13
    else
      o_output_state <= dac_ctrl_pkg::OUT_NORMAL;               // R13
  end

  // Checks
  sequence s_sw_load_alone;
    sw_load && !sw_clear && !sw_reset && clear_sync;
  endsequence

  sequence s_sw_clear_alone;
    sw_clear && !sw_reset && load_sync;
  endsequence

  a_load_transfer : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    s_sw_load_alone |=> (dac_reg == $past(input_reg)) && o_dac_update) // R3
    else $error("software load did not transfer input value");

  a_clear_code : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    s_sw_clear_alone |=> (dac_reg == $past(clear_code)) && o_dac_update) // R4
    else $error("software clear did not load clear code");

  a_clear_blocked : assert property (@(posedge i_clk_sys)
    disable iff (!rst_b)
    pin_clear_fall && !load_sync && !frame_valid |=> !o_dac_update) // R7
    else $error("clear acted while load pin low");

  a_load_blocked : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    pin_load_fall && !clear_sync && !frame_valid |=> !o_dac_update) // R8
    else $error("load acted while clear pin low");

  a_soft_reset : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    sw_reset |=> o_output_ground_clamp && o_converter_float_ctrl
      && !o_code_format_select && dac_reg == dac_ctrl_pkg::DAC_RESET
      ##1 o_output_state == dac_ctrl_pkg::OUT_CLAMP) // R6
    else $error("software reset did not restore power-on state");

  a_power_on : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    $rose(rst_b) |-> o_output_ground_clamp && o_converter_float_ctrl
      && o_feedback_resistor_select && !o_code_format_select
      && o_output_state == dac_ctrl_pkg::OUT_CLAMP) // R9
    else $error("power-on defaults wrong");

  a_clamp_holds : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    o_output_ground_clamp && !(wr && frame.addr == dac_ctrl_pkg::ADDR_CTRL)
      |=> o_output_ground_clamp) // R10
    else $error("ground clamp dropped without control write");

  a_state_decode : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    1'b1 |=> o_output_state == ($past(o_output_ground_clamp)
      ? dac_ctrl_pkg::OUT_CLAMP : ($past(o_converter_float_ctrl)
      ? dac_ctrl_pkg::OUT_TRISTATE : dac_ctrl_pkg::OUT_NORMAL))) // R13
    else $error("output state decode wrong");

  a_code_format : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    !o_code_format_select && $stable(dac_reg) && $stable(o_code_format_select)
      |=> o_dac_code[DATA_W-1] == !$past(dac_reg[DATA_W-1])) // R5
    else $error("twos complement code not converted");

  a_feedback_sel : assert property (@(posedge i_clk_sys) disable iff (!rst_b)
    wr && frame.addr == dac_ctrl_pkg::ADDR_CTRL && !sw_reset
      |=> o_feedback_resistor_select
        == $past(frame.data[dac_ctrl_pkg::CTRL_FB_BIT])) // R14
    else $error("feedback select not written");

endmodule : dac_output_state_control

// ===== tb/serial_host_model.sv
// Serial host model writing command frames to the converter
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_start,
  input  wire dac_ctrl_pkg::frame_s i_frame,
  input  wire logic [4:0]           i_bits,
  input  wire logic                 i_slow,
  output logic                      o_sclk,
  output logic                      o_sync_b,
  output logic                      o_sdin,
  output logic                      o_busy
);
  int k;
  initial begin
    o_sclk = 1'b1;
    o_sync_b = 1'b1;
    o_sdin = 1'b0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      if (i_start) begin
        o_busy = 1'b1;
        #7 o_sync_b = 1'b0;
        for (k = 0; k < i_bits; k++) begin
          o_sdin = i_frame[23-k];
          #160 o_sclk = 1'b0;
          #160 o_sclk = 1'b1;
          if (i_slow) #480;
        end
        #160 o_sync_b = 1'b1;
        // Released line shows no stale bit
        o_sdin = ~o_sdin;
        #200 o_busy = 1'b0;
      end
    end
  end
endmodule : serial_host_model

// ===== tb/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
  mismatches++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic                        clk_sys = 1'b0;
  logic                        rst_b = 1'b0;
  logic                        load_b = 1'b1;
  logic                        clear_b = 1'b1;
  logic                        start = 1'b0;
  logic                        slow = 1'b0;
  logic [4:0]                  bits = 5'h18;
  dac_ctrl_pkg::frame_s        frame = '0;
  logic                        sclk, sync_b, sdin, busy;
  logic [15:0]                 dac_code;
  logic                        dac_update, float_c, clamp, fb, fmt;
  dac_ctrl_pkg::output_state_e out_state;
  logic [31:0]                 lfsr = 32'h1e5f;
  logic [15:0]                 exp_q[$];
  logic [15:0]                 v, c;
  int                          mismatches = 0;
  int                          comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  dac_output_state_control dac_output_state_control_i (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_sclk(sclk),
    .i_sync_b(sync_b), .i_sdin(sdin), .i_load_output_strobe_b(load_b),
    .i_clear_to_code_b(clear_b), .o_dac_code(dac_code),
    .o_dac_update(dac_update), .o_output_state(out_state),
    .o_converter_float_ctrl(float_c), .o_output_ground_clamp(clamp),
    .o_feedback_resistor_select(fb), .o_code_format_select(fmt));

  serial_host_model serial_host_model_i (
    .i_clk_sys(clk_sys), .i_start(start), .i_frame(frame),
    .i_bits(bits), .i_slow(slow), .o_sclk(sclk), .o_sync_b(sync_b),
    .o_sdin(sdin), .o_busy(busy));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic send(input logic [23:0] f, input logic [4:0] n);
    int i;
    frame <= f;
    bits <= n;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 1000 && busy === 1'b1; i++) @(posedge clk_sys);
    if (i == 1000) begin
      mismatches++;
      final_report();
    end
    repeat (8) @(posedge clk_sys);
  endtask : send

  task automatic sw(input logic [2:0] b);
    send({1'b0, dac_ctrl_pkg::ADDR_SWCTRL, 17'h0, b}, 5'd24);
  endtask : sw

  task automatic pulse(input logic ld);
    if (ld) load_b <= 1'b0;
    else clear_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    load_b <= 1'b1;
    clear_b <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : pulse

  task automatic chk_ctl(input logic fl, cl, f, m,
                         input dac_ctrl_pkg::output_state_e st);
    `CHK("float", fl, float_c)
    `CHK("clamp", cl, clamp)
    `CHK("fb", f, fb)
    `CHK("fmt", m, fmt)
    `CHK("state", st, out_state)
  endtask : chk_ctl

  // Each update pulse takes the oldest expected code
  initial begin
    logic [15:0] e;
    forever begin
      @(posedge clk_sys);
      #1;
      if (dac_update === 1'b1) begin
        @(posedge clk_sys);
        #1;
        e = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
        `CHK("dac_code", e, dac_code)
      end
    end
  end

  initial begin
    logic fl, cl, f;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_ctl(1'b1, 1'b1, 1'b1, 1'b0, dac_ctrl_pkg::OUT_CLAMP);
    for (int i = 3; i >= 0; i--) begin
      lfsr = next_rand(lfsr);
      fl = i[1];
      cl = i[0];
      f = (i == 0) ? 1'b0 : lfsr[0];
      send({1'b0, dac_ctrl_pkg::ADDR_CTRL, 15'h0, 1'b0, fl, cl, f, 1'b0},
           5'd24);
      chk_ctl(fl, cl, f, 1'b0, cl ? dac_ctrl_pkg::OUT_CLAMP :
              fl ? dac_ctrl_pkg::OUT_TRISTATE : dac_ctrl_pkg::OUT_NORMAL);
    end
    `CHK("code", 16'h0000, dac_code)
    lfsr = next_rand(lfsr);
    v = lfsr[15:0];
    send({1'b0, dac_ctrl_pkg::ADDR_DAC, v, 4'h0}, 5'd24);
    exp_q.push_back(v ^ 16'h8000);
    sw(3'h1);
    lfsr = next_rand(lfsr);
    c = lfsr[15:0];
    send({1'b0, dac_ctrl_pkg::ADDR_CLEARCODE, c, 4'h0}, 5'd24);
    exp_q.push_back(c ^ 16'h8000);
    sw(3'h2);
    send({1'b0, dac_ctrl_pkg::ADDR_CTRL, 20'h00010}, 5'd24);
    exp_q.push_back(c);
    sw(3'h2);
    lfsr = next_rand(lfsr);
    v = lfsr[15:0];
    send({1'b0, dac_ctrl_pkg::ADDR_DAC, v, 4'h0}, 5'd24);
    exp_q.push_back(v);
    pulse(1'b1);
    exp_q.push_back(c);
    pulse(1'b0);
    // Held load pin blocks a clear
    exp_q.push_back(v);
    load_b <= 1'b0;
    sw(3'h2);
    pulse(1'b0);
    // Held clear pin blocks a load
    exp_q.push_back(c);
    clear_b <= 1'b0;
    sw(3'h1);
    pulse(1'b1);
    // Short frame and read frame are dropped
    send({1'b0, dac_ctrl_pkg::ADDR_CTRL, 20'h0000e}, 5'd23);
    send({1'b1, dac_ctrl_pkg::ADDR_CTRL, 20'h0000e}, 5'd24);
    chk_ctl(1'b0, 1'b0, 1'b0, 1'b1, dac_ctrl_pkg::OUT_NORMAL);
    sw(3'h4);
    chk_ctl(1'b1, 1'b1, 1'b1, 1'b0, dac_ctrl_pkg::OUT_CLAMP);
    `CHK("code", 16'h0000, dac_code)
    slow <= 1'b1;
    exp_q.push_back(16'h0000);
    sw(3'h1);
    `CHK("pending", 0, exp_q.size())
    final_report();
  end
endmodule : tb_top
